// File: core/gpr_regs.vh
/*
 Register offsets, field layout and reset values of the GPIO port register file.
 Included by the port register file module; definitions only.
*/
`ifndef GPR_REGS_VH
`define GPR_REGS_VH

`define GPR_OFF_MODE        8'h00
`define GPR_OFF_OTYPE       8'h04
`define GPR_OFF_SPEED       8'h08
`define GPR_OFF_PULL        8'h0C
`define GPR_OFF_IN          8'h10
`define GPR_OFF_OUT         8'h14
`define GPR_OFF_SETCLR      8'h18
`define GPR_OFF_LOCK        8'h1C
`define GPR_OFF_ALTLO       8'h20
`define GPR_OFF_ALTHI       8'h24
`define GPR_OFF_CLRONLY     8'h28

`define GPR_MODE_RST_A      32'h28000000
`define GPR_PULL_RST_A      32'h24000000
`define GPR_ZERO_RST        32'h00000000

`define GPR_KEY_BIT         16
`define GPR_CLR_LSB         16

`define GPR_MODE_INPUT      2'h0
`define GPR_MODE_OUTPUT     2'h1
`define GPR_MODE_ALT        2'h2
`define GPR_MODE_ANALOG     2'h3

`endif

// File: core/gpr_port.v
/*
 GPIO port register file: mode, output type, speed, pull, alternate-function
 selection, output latch with atomic set/clear, sampled inputs, and the
 configuration lock with key sequence.
 Assumes a classic Wishbone master on clk_i, raw pin levels from outside the
 clock domain, and alternate-function peripheral outputs on clk_i.
*/
// Design decision made here: the Wishbone register port.
// Operation
// - Two-bit mode per pin: 00 input (reset), 01 output, 10 alternate, 11 analog.
// - One output-type bit per pin in 15:0: 0 push-pull, 1 open-drain.
// - Two-bit speed per pin: x0 low, 01 medium, 11 high.
// - Two-bit pull per pin: 00 none, 01 pull-up, 10 pull-down, 11 reserved.
// - Input register bits 15:0 show sampled pin levels; read-only, upper half zero.
// - Sixteen-bit output latch, read and write, resets to zero.
// - Writing one to set/clear bit y sets latch bit y; zero no effect.
// - Writing one to set/clear bit 16+y clears latch bit y.
// - Set/clear register reads back as zero.
// - Set and clear of same pin in one write: set wins.
// - Clear-only register bit y clears latch bit y; reads zero.
// - Lock bits writable only while key inactive; always readable.
// - With key active, locked pins keep configuration until reset.
// - Pattern must stay constant; any deviation abandons activation.
// - After successful sequence key bit reads one until reset.
// - Lock register exists only on ports A and B.
// - Four-bit alternate selector for pins 0 to 7 in low register.
// - Same selectors for pins 8 to 15 in high register, reset zero.
// - Port A mode register resets nonzero for debug pins.
// - Port A pull register resets nonzero for debug pins.
// - Pins resampled each clock in input, output or alternate mode.
// - Analog pins read zero in the input register.
// - Alternate mode drives pin from selected peripheral, not the latch.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.vh"

module gpr_port #(
	parameter IS_PORT_A = 1,
	parameter HAS_LOCK  = 1,
	parameter NPIN      = 16,
	parameter NAF       = 8
) (
	input  wire               clk_i,
	input  wire               rst_i,
	input  wire               wb_cyc_i,
	input  wire               wb_stb_i,
	input  wire               wb_we_i,
	input  wire [7:0]         wb_adr_i,
	input  wire [3:0]         wb_sel_i,
	input  wire [31:0]        wb_dat_i,
	output reg  [31:0]        wb_dat_o,
	output reg                wb_ack_o,
	input  wire [NPIN-1:0]    pin_level_i,
	input  wire [NPIN*NAF-1:0] af_out_i,
	output reg  [NPIN-1:0]    pin_out_o,
	output reg  [NPIN-1:0]    pin_oe_o,
	output reg  [NPIN-1:0]    pin_open_drain_o,
	output reg  [2*NPIN-1:0]  pin_slew_code_o,
	output reg  [NPIN-1:0]    pin_pull_up_o,
	output reg  [NPIN-1:0]    pin_pull_down_o,
	output reg  [NPIN-1:0]    pin_af_sel_o
);

	localparam [3:0] KS_IDLE = 4'b0001;
	localparam [3:0] KS_ONE  = 4'b0010;
	localparam [3:0] KS_ZERO = 4'b0100;
	localparam [3:0] KS_DONE = 4'b1000;

	reg  [31:0]     pin_function_code_r;
	reg  [15:0]     pin_drive_type_r;
	reg  [31:0]     pin_slew_code_r;
	reg  [31:0]     pin_pull_code_r;
	reg  [31:0]     alt_lo_r;
	reg  [31:0]     alt_hi_r;
	reg  [15:0]     pin_output_latch_bit_r;
	reg  [15:0]     pin_freeze_bit_r;
	reg             freeze_key_bit_r;
	reg  [3:0]      key_state_r;
	reg  [3:0]      key_state_nxt;
	reg  [15:0]     key_pattern_r;
	reg  [NPIN-1:0] sync1_r;
	reg  [NPIN-1:0] sync2_r;
	reg  [15:0]     pin_sampled_level_r;
	reg  [15:0]     latch_nxt;
	reg  [31:0]     rd_data;

	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr      = req & wb_we_i & (&wb_sel_i);
	wire        rd      = req & ~wb_we_i;
	wire        lock_on = (HAS_LOCK != 0);
	wire [15:0] frozen  = freeze_key_bit_r ? pin_freeze_bit_r : 16'h0000;

	// Mask of 2-bit fields writable for unfrozen pins
	function [31:0] mask2;
		input [15:0] fr;
		integer k;
		begin
			mask2 = 32'h00000000;
			for (k = 0; k < 16; k = k + 1) begin
				mask2[2*k +: 2] = {2{~fr[k]}};
			end
		end
	endfunction

	// Mask of 4-bit fields for eight pins
	function [31:0] mask4;
		input [7:0] fr;
		integer k;
		begin
			mask4 = 32'h00000000;
			for (k = 0; k < 8; k = k + 1) begin
				mask4[4*k +: 4] = {4{~fr[k]}};
			end
		end
	endfunction

	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [31:0] m;
		begin
			merge = (old_v & ~m) | (new_v & m);
		end
	endfunction

	// True when a pin's two-bit mode equals the given code
	function is_mode;
		input [1:0] fn_v;
		input [1:0] code;
		begin
			is_mode = (fn_v == code);
		end
	endfunction

	// Configuration registers
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_function_code_r <= IS_PORT_A ? `GPR_MODE_RST_A : `GPR_ZERO_RST;
			pin_drive_type_r    <= 16'h0000;
			pin_slew_code_r     <= `GPR_ZERO_RST;
			pin_pull_code_r     <= IS_PORT_A ? `GPR_PULL_RST_A : `GPR_ZERO_RST;
			alt_lo_r            <= `GPR_ZERO_RST;
			alt_hi_r            <= `GPR_ZERO_RST;
		end else if (wr) begin
			case (wb_adr_i)
				`GPR_OFF_MODE: begin
					pin_function_code_r <=
						merge(pin_function_code_r, wb_dat_i, mask2(frozen));
				end
				`GPR_OFF_OTYPE: begin
					pin_drive_type_r <=
						(pin_drive_type_r & frozen) | (wb_dat_i[15:0] & ~frozen);
				end
				`GPR_OFF_SPEED: begin
					pin_slew_code_r <=
						merge(pin_slew_code_r, wb_dat_i, mask2(frozen));
				end
				`GPR_OFF_PULL: begin
					pin_pull_code_r <=
						merge(pin_pull_code_r, wb_dat_i, mask2(frozen));
				end
				`GPR_OFF_ALTLO: begin
					alt_lo_r <=
						merge(alt_lo_r, wb_dat_i, mask4(frozen[7:0]));
				end
				`GPR_OFF_ALTHI: begin
					alt_hi_r <=
						merge(alt_hi_r, wb_dat_i, mask4(frozen[15:8]));
				end
				default: begin
				end
			endcase
		end
	end

	// Output latch with direct, set/clear and clear-only access
	always @* begin
		latch_nxt = pin_output_latch_bit_r;
		if (wr) begin
			case (wb_adr_i)
				`GPR_OFF_OUT: begin
					latch_nxt = wb_dat_i[15:0];
				end
				`GPR_OFF_SETCLR: begin
					latch_nxt = (pin_output_latch_bit_r
						& ~wb_dat_i[31:`GPR_CLR_LSB]) | wb_dat_i[15:0];
				end
				`GPR_OFF_CLRONLY: begin
					latch_nxt = pin_output_latch_bit_r & ~wb_dat_i[15:0];
				end
				default: begin
					latch_nxt = pin_output_latch_bit_r;
				end
			endcase
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_output_latch_bit_r <= 16'h0000;
		end else begin
			pin_output_latch_bit_r <= latch_nxt;
		end
	end

	// Lock key sequence
	wire key_wr  = wr & lock_on & (wb_adr_i == `GPR_OFF_LOCK);
	wire key_bit = wb_dat_i[`GPR_KEY_BIT];
	wire same_pt = (wb_dat_i[15:0] == key_pattern_r);

	always @* begin
		key_state_nxt = key_state_r;
		if (!freeze_key_bit_r && req) begin
			case (key_state_r)
				KS_IDLE: begin
					if (key_wr && key_bit) begin
						key_state_nxt = KS_ONE;
					end else begin
						key_state_nxt = KS_IDLE;
					end
				end
				KS_ONE: begin
					if (key_wr && !key_bit && same_pt) begin
						key_state_nxt = KS_ZERO;
					end else if (key_wr && key_bit) begin
						key_state_nxt = KS_ONE;
					end else begin
						key_state_nxt = KS_IDLE;
					end
				end
				KS_ZERO: begin
					if (key_wr && key_bit && same_pt) begin
						key_state_nxt = KS_DONE;
					end else if (key_wr && key_bit) begin
						key_state_nxt = KS_ONE;
					end else begin
						key_state_nxt = KS_IDLE;
					end
				end
				KS_DONE: begin
					key_state_nxt = KS_IDLE;
				end
				default: begin
					key_state_nxt = KS_IDLE;
				end
			endcase
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_state_r      <= KS_IDLE;
			key_pattern_r    <= 16'h0000;
			pin_freeze_bit_r <= 16'h0000;
			freeze_key_bit_r <= 1'b0;
		end else begin
			key_state_r <= key_state_nxt;
			if (key_wr && !freeze_key_bit_r) begin
				pin_freeze_bit_r <= wb_dat_i[15:0];
				key_pattern_r    <= wb_dat_i[15:0];
			end
			if (key_state_nxt == KS_DONE) begin
				freeze_key_bit_r <= 1'b1;
			end
		end
	end

	// Pin sampling through three flip-flops
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_pin
			wire [1:0] fn  = pin_function_code_r[2*g +: 2];
			wire [3:0] sel = (g < 8) ? alt_lo_r[4*(g%8) +: 4] : alt_hi_r[4*(g%8) +: 4];
			wire       af  = (sel < NAF) ? af_out_i[g*NAF + (sel % NAF)] : 1'b0;
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_r[g]             <= 1'b0;
					sync2_r[g]             <= 1'b0;
					pin_sampled_level_r[g] <= 1'b0;
					pin_out_o[g]           <= 1'b0;
					pin_oe_o[g]            <= 1'b0;
					pin_af_sel_o[g]        <= 1'b0;
				end else begin
					sync1_r[g] <= pin_level_i[g];
					sync2_r[g] <= sync1_r[g];
					// Analog pins read zero, others follow the pin
					if (is_mode(fn, `GPR_MODE_ANALOG)) begin
						pin_sampled_level_r[g] <= 1'b0;
					end else begin
						pin_sampled_level_r[g] <= sync2_r[g];
					end
					// Alternate pins take the peripheral, others the latch
					if (is_mode(fn, `GPR_MODE_ALT)) begin
						pin_out_o[g] <= af;
					end else begin
						pin_out_o[g] <= latch_nxt[g];
					end
					pin_oe_o[g]     <= is_mode(fn, `GPR_MODE_OUTPUT) || is_mode(fn, `GPR_MODE_ALT);
					pin_af_sel_o[g] <= is_mode(fn, `GPR_MODE_ALT);
				end
			end
		end
	endgenerate

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_open_drain_o <= 16'h0000;
			pin_slew_code_o  <= 32'h00000000;
			pin_pull_up_o    <= 16'h0000;
			pin_pull_down_o  <= 16'h0000;
		end else begin
			pin_open_drain_o <= pin_drive_type_r;
			pin_slew_code_o  <= pin_slew_code_r;
			pin_pull_up_o    <= pull_bits(pin_pull_code_r, pin_function_code_r, 1'b0);
			pin_pull_down_o  <= pull_bits(pin_pull_code_r, pin_function_code_r, 1'b1);
		end
	end

	// Pull enables, off in analog mode and for reserved code
	function [15:0] pull_bits;
		input [31:0] pc;
		input [31:0] fc;
		input        dn;
		integer k;
		begin
			pull_bits = 16'h0000;
			for (k = 0; k < 16; k = k + 1) begin
				pull_bits[k] = (fc[2*k +: 2] != `GPR_MODE_ANALOG) &&
					(pc[2*k +: 2] == (dn ? 2'h2 : 2'h1));
			end
		end
	endfunction

	// Read mux
	always @* begin
		case (wb_adr_i)
			`GPR_OFF_MODE:    rd_data = pin_function_code_r;
			`GPR_OFF_OTYPE:   rd_data = {16'h0000, pin_drive_type_r};
			`GPR_OFF_SPEED:   rd_data = pin_slew_code_r;
			`GPR_OFF_PULL:    rd_data = pin_pull_code_r;
			`GPR_OFF_IN:      rd_data = {16'h0000, pin_sampled_level_r};
			`GPR_OFF_OUT:     rd_data = {16'h0000, pin_output_latch_bit_r};
			`GPR_OFF_SETCLR:  rd_data = 32'h00000000;
			`GPR_OFF_LOCK: begin
				if (lock_on) begin
					rd_data = {15'h0000, freeze_key_bit_r, pin_freeze_bit_r};
				end else begin
					rd_data = 32'h00000000;
				end
			end
			`GPR_OFF_ALTLO:   rd_data = alt_lo_r;
			`GPR_OFF_ALTHI:   rd_data = alt_hi_r;
			`GPR_OFF_CLRONLY: rd_data = 32'h00000000;
			default:          rd_data = 32'h00000000;
		endcase
	end

	// Wishbone answer one cycle after request
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rd_data : 32'h00000000;
		end
	end

endmodule // gpr_port
`default_nettype wire

// File: testbench/gpr_port_checker.sv
/* Checker of the GPIO port register file: bus answers and pin outputs.
   Assumes it is bound to gpr_port and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module gpr_port_checker #(
	parameter NPIN = 16
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_o,
	input  wire logic              wb_ack_o,
	input  wire logic [NPIN-1:0]   pin_oe_o,
	input  wire logic [NPIN-1:0]   pin_open_drain_o,
	input  wire logic [2*NPIN-1:0] pin_slew_code_o,
	input  wire logic [NPIN-1:0]   pin_pull_up_o,
	input  wire logic [NPIN-1:0]   pin_pull_down_o,
	input  wire logic [NPIN-1:0]   pin_af_sel_o
);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire rd  = req && !wb_we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack missing or too long");
	idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	setclr_read_a: assert property (rd && wb_adr_i == 8'h18 |=> wb_dat_o == 32'h0)
		else $error("set/clear read not zero");
	clronly_read_a: assert property (rd && wb_adr_i == 8'h28 |=> wb_dat_o == 32'h0)
		else $error("clear-only read not zero");
	in_upper_a: assert property (rd && wb_adr_i == 8'h10 |=> wb_dat_o[31:16] == 16'h0)
		else $error("input upper half not zero");
	lock_upper_a: assert property (rd && wb_adr_i == 8'h1C |=> wb_dat_o[31:17] == 15'h0)
		else $error("lock upper bits not zero");
	otype_view_a: assert property (rd && wb_adr_i == 8'h04 |=> wb_dat_o == 32'(pin_open_drain_o))
		else $error("drive type read differs from pins");
	speed_view_a: assert property (rd && wb_adr_i == 8'h08 |=> wb_dat_o == pin_slew_code_o)
		else $error("speed read differs from pins");
	pull_excl_a: assert property ((pin_pull_up_o & pin_pull_down_o) == '0)
		else $error("pull-up and pull-down together");
	af_drive_a: assert property ((pin_af_sel_o & ~pin_oe_o) == '0)
		else $error("alternate pin not driven");
endmodule // gpr_port_checker
bind gpr_port gpr_port_checker #(.NPIN(NPIN)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_oe_o, .pin_open_drain_o,
	.pin_slew_code_o, .pin_pull_up_o, .pin_pull_down_o, .pin_af_sel_o);
`default_nettype wire

// File: testbench/gpr_pins.sv
/* Model of the pins and peripherals around one GPIO port.
   Assumes the port's pin outputs and an external level from the bench. */
`timescale 1ns/1ps
`default_nettype none
module gpr_pins (
	input  wire logic [15:0]  drv_i,
	input  wire logic [15:0]  oe_i,
	input  wire logic [15:0]  od_i,
	input  wire logic [15:0]  ext_i,
	output logic      [15:0]  lvl_o,
	output logic      [127:0] af_o
);
	// Released or open-drain high pins show the outside level
	always_comb begin
		for (int g = 0; g < 16; g++) begin
			lvl_o[g] = (oe_i[g] && !(od_i[g] && drv_i[g])) ? drv_i[g] : ext_i[g];
		end
	end
	// Odd peripheral functions drive one, even ones zero
	assign af_o = {16{8'hAA}};
endmodule // gpr_pins
`default_nettype wire

// File: testbench/tb_gpr_port.sv
/* Testbench of the GPIO port register file over classic Wishbone.
   Assumes gpr_port, its bound checker and the pin model gpr_pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_gpr_port;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q;
	logic [15:0] ext = 16'h1234;
	int          fails = 0;
	int          cmp_count = 0;
	wire [31:0]  dat, slew;
	wire         ack;
	wire [15:0]  lvl, pout, oe, od, pu, pd, afs;
	wire [127:0] af;
	always #5 clk_i = ~clk_i;
	gpr_port #(.IS_PORT_A(1), .HAS_LOCK(1)) i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(dat), .wb_ack_o(ack), .pin_level_i(lvl), .af_out_i(af), .pin_out_o(pout),
		.pin_oe_o(oe), .pin_open_drain_o(od), .pin_slew_code_o(slew), .pin_pull_up_o(pu),
		.pin_pull_down_o(pd), .pin_af_sel_o(afs));
	gpr_pins i_pins (.drv_i(pout), .oe_i(oe), .od_i(od), .ext_i(ext), .lvl_o(lvl), .af_o(af));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk({31'h0, ack}, 32'h1);
		r = dat;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF, q);
		chk(q, e);
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({16'h0, oe}, 32'h6000);
		chk({pu, pd}, 32'h20004000);
		rc(8'h00, 32'h28000000);
		rc(8'h0C, 32'h24000000);
		rc(8'h04, 32'h0);
		rc(8'h08, 32'h0);
		rc(8'h14, 32'h0);
		rc(8'h1C, 32'h0);
		rc(8'h20, 32'h0);
		rc(8'h24, 32'h0);
		$display("test reset values done");
		wr(8'h14, 32'h0000A5A5);
		rc(8'h14, 32'h0000A5A5);
		wr(8'h18, 32'h00FF0F00);
		rc(8'h14, 32'h0000AF00);
		wr(8'h18, 32'h00010001);
		rc(8'h14, 32'h0000AF01);
		rc(8'h18, 32'h0);
		wr(8'h28, 32'h00000100);
		rc(8'h14, 32'h0000AE01);
		rc(8'h28, 32'h0);
		bus(1'b1, 8'h14, 32'h0, 4'h3, q);
		rc(8'h14, 32'h0000AE01);
		$display("test output latch done");
		wr(8'h00, 32'h55555555);
		rc(8'h00, 32'h55555555);
		chk({oe, pout}, 32'hFFFFAE01);
		wr(8'h04, 32'hFFFFFFFF);
		rc(8'h04, 32'h0000FFFF);
		chk({16'h0, od}, 32'h0000FFFF);
		wr(8'h08, 32'h0000C0DE);
		rc(8'h08, 32'h0000C0DE);
		chk(slew, 32'h0000C0DE);
		wr(8'h0C, 32'h00000006);
		chk({pu, pd}, 32'h00020001);
		wr(8'h00, 32'h0);
		repeat (4) @(posedge clk_i);
		rc(8'h10, 32'h00001234);
		wr(8'h00, 32'hFFFFFFFF);
		repeat (4) @(posedge clk_i);
		rc(8'h10, 32'h0);
		chk({oe, pu}, 32'h0);
		wr(8'h20, 32'h76543210);
		wr(8'h24, 32'h01234567);
		wr(8'h00, 32'hAAAAAAAA);
		chk({afs, pout}, 32'hFFFF55AA);
		$display("test pin modes done");
		wr(8'h1C, 32'h00010001);
		bus(1'b0, 8'h00, 32'h0, 4'hF, q);
		wr(8'h1C, 32'h00000001);
		wr(8'h1C, 32'h00010001);
		rc(8'h1C, 32'h00000001);
		wr(8'h1C, 32'h00010003);
		wr(8'h1C, 32'h00000007);
		wr(8'h1C, 32'h00010007);
		rc(8'h1C, 32'h00000007);
		wr(8'h1C, 32'h00010003);
		wr(8'h1C, 32'h00000003);
		wr(8'h1C, 32'h00010003);
		rc(8'h1C, 32'h00010003);
		wr(8'h1C, 32'h0);
		rc(8'h1C, 32'h00010003);
		wr(8'h00, 32'h0);
		rc(8'h00, 32'h0000000A);
		wr(8'h20, 32'h0);
		rc(8'h20, 32'h00000010);
		wr(8'h14, 32'h0000FFFF);
		rc(8'h14, 32'h0000FFFF);
		wr(8'h2C, 32'hFFFFFFFF);
		rc(8'h2C, 32'h0);
		$display("test lock done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h1C, 32'h0);
		rc(8'h00, 32'h28000000);
		$display("test second reset done");
		end_of_test;
	end
endmodule // tb_gpr_port
`default_nettype wire
